// ===== logic/perf_monitor_counters.sv
`timescale 1ns/100ps
module perf_monitor_counters
    import perf_monitor_pkg::*;
(
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Move-to / move-from special register port
    input  wire logic [9:0]   spr_num,
    input  wire logic         spr_write,
    input  wire logic         spr_read,
    input  wire logic [31:0]  spr_wdata,
    output logic      [31:0]  spr_rdata,
    output logic              spr_rvalid,
    output logic              spr_fault,
    // Machine state
    input  wire logic         user_state_flag,
    input  wire logic         mark_flag,
    input  wire logic         external_irq_gate,
    input  wire logic         exception_taken,
    // Time base and event sources
    input  wire logic [63:0]  timebase,
    input  wire logic [127:0] c1_events,
    input  wire logic [63:0]  c2_events,
    input  wire logic [31:0]  c3_events,
    input  wire logic [31:0]  c4_events,
    // Instruction addresses for sampling
    input  wire logic         threshold_event,
    input  wire logic [31:0]  threshold_instr_addr,
    input  wire logic [31:0]  completed_addr,
    // Monitor results
    output logic      [5:0]   threshold_value,
    output logic              monitor_irq_pending,
    output logic              monitor_exception
);

    logic [31:0]      monitor_control_0;
    logic [31:0]      monitor_control_1;
    logic [3:0][31:0] cnt;
    logic [31:0]      sampled_addr;
    logic             irq_frozen;
    logic             chain_released;
    logic             tb_prev;
    logic             tb_bit;
    logic             tb_rise;
    logic             irq_signal;
    logic             wr_ok;
    logic             mc0_wr;
    logic             mc1_wr;
    logic             saddr_wr;
    logic [3:0]       wr_cnt;
    logic [3:0]       hit;
    logic [3:0]       count_ok;
    logic             base_ok;
    logic             others_ok;
    logic [31:0]      next_rdata;
    logic             next_fault;

    // Writes take effect only from supervisor state
    assign wr_ok     = spr_write && !user_state_flag;
    assign mc0_wr    = wr_ok && spr_num == SPR_MC0;
    assign mc1_wr    = wr_ok && spr_num == SPR_MC1;
    assign saddr_wr  = wr_ok && spr_num == SPR_SADDR;
    assign wr_cnt[0] = wr_ok && spr_num == SPR_CNT1;
    assign wr_cnt[1] = wr_ok && spr_num == SPR_CNT2;
    assign wr_cnt[2] = wr_ok && spr_num == SPR_CNT3;
    assign wr_cnt[3] = wr_ok && spr_num == SPR_CNT4;

    // Time base tap select
    always_comb begin
        unique case (monitor_control_0[TB_PICK_LSB +: TB_PICK_W])
            2'h0: tb_bit = timebase[TB_TAP_0];
            2'h1: tb_bit = timebase[TB_TAP_1];
            2'h2: tb_bit = timebase[TB_TAP_2];
            2'h3: tb_bit = timebase[TB_TAP_3];
        endcase
    end

    // Previous tap starts high so reset release never looks like an edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            tb_prev <= 1'b1;
        end else begin
            tb_prev <= tb_bit;
        end
    end

    assign tb_rise = tb_bit && !tb_prev;

    // Signaling is level based on the top bits, so a loaded overflow value signals too
    assign irq_signal = monitor_control_0[IRQ_ARM_BIT] && (
        (monitor_control_0[C1_IRQ_BIT] && cnt[0][WRAP_BIT]) ||
        (monitor_control_0[OTHER_IRQ_BIT] &&
         (cnt[1][WRAP_BIT] || cnt[2][WRAP_BIT] || cnt[3][WRAP_BIT])) ||
        (monitor_control_0[TB_EDGE_BIT] && tb_rise));

    // Control register 0; hardware only ever drops the arm bit
    always_ff @(posedge core_clk) begin
        if (rst) begin
            monitor_control_0 <= CTRL_RESET;
        end else if (mc0_wr) begin
            monitor_control_0 <= spr_wdata;
        end else if (irq_signal) begin
            monitor_control_0[IRQ_ARM_BIT] <= 1'b0;
        end
    end

    // Control register 1; reserved bits never store
    always_ff @(posedge core_clk) begin
        if (rst) begin
            monitor_control_1 <= CTRL_RESET;
        end else if (mc1_wr) begin
            monitor_control_1 <= spr_wdata & MC1_MASK;
        end
    end

    assign threshold_value = monitor_control_0[THRESH_LSB +: THRESH_W];

    // Freeze after signaling lasts until software rewrites control register 0
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq_frozen <= 1'b0;
        end else if (irq_signal && monitor_control_0[FREEZE_IRQ_BIT]) begin
            irq_frozen <= 1'b1;
        end else if (mc0_wr) begin
            irq_frozen <= 1'b0;
        end
    end

    // Chain release; set wins over the clear from a control write
    always_ff @(posedge core_clk) begin
        if (rst) begin
            chain_released <= 1'b0;
        end else if (cnt[0][WRAP_BIT] || irq_signal) begin
            chain_released <= 1'b1;
        end else if (mc0_wr) begin
            chain_released <= 1'b0;
        end
    end

    // Pending condition; exception waits on the gate
    always_ff @(posedge core_clk) begin
        if (rst) begin
            monitor_irq_pending <= 1'b0;
        end else if (irq_signal) begin
            monitor_irq_pending <= 1'b1;
        end else if (exception_taken) begin
            monitor_irq_pending <= 1'b0;
        end
    end

    assign monitor_exception = monitor_irq_pending && external_irq_gate;

    // Common counting permission from state and freeze bits
    assign base_ok = !monitor_control_0[FREEZE_ALL_BIT]
        && !(monitor_control_0[SUP_BLOCK_BIT] && !user_state_flag)
        && !(monitor_control_0[USER_BLOCK_BIT] && user_state_flag)
        && !(monitor_control_0[MARK_SET_BIT] && mark_flag)
        && !(monitor_control_0[MARK_CLR_BIT] && !mark_flag);

    // Counters 2-4 escape the freeze when their own enable is set
    assign others_ok = base_ok
        && (!irq_frozen || monitor_control_0[OTHER_IRQ_BIT])
        && (!monitor_control_0[CHAIN_HOLD_BIT] || chain_released);

    assign count_ok = {others_ok, others_ok, others_ok, base_ok && !irq_frozen};

    // Event selection per counter
    assign hit[0] = c1_events[monitor_control_0[C1_SEL_LSB +: C1_SEL_W]];
    assign hit[1] = c2_events[monitor_control_0[C2_SEL_LSB +: C2_SEL_W]];
    assign hit[2] = c3_events[monitor_control_1[C3_SEL_LSB +: C34_SEL_W]];
    assign hit[3] = c4_events[monitor_control_1[C4_SEL_LSB +: C34_SEL_W]];

    // Counters; a software load wins over a same-cycle event
    for (genvar i = 0; i < 4; i++) begin : g_cnt
        always_ff @(posedge core_clk) begin
            if (rst) begin
                cnt[i] <= CNT_RESET;
            end else if (wr_cnt[i]) begin
                cnt[i] <= spr_wdata;
            end else if (count_ok[i] && hit[i]) begin
                cnt[i] <= cnt[i] + 32'h0000_0001;
            end
        end
    end

    sampled_addr_capture u_sample (
        .core_clk             (core_clk),
        .rst                  (rst),
        .thresh_counted       (threshold_event && |(count_ok & hit)),
        .threshold_instr_addr (threshold_instr_addr),
        .completed_addr       (completed_addr),
        .irq_signal           (irq_signal),
        .sw_write             (saddr_wr),
        .sw_wdata             (spr_wdata),
        .sampled_addr         (sampled_addr)
    );

    // Read decode and faults; user views read live state from any level
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_fault = 1'b0;
        if (spr_read) begin
            unique case (spr_num)
                SPR_U_MC0:   next_rdata = monitor_control_0;
                SPR_U_CNT1:  next_rdata = cnt[0];
                SPR_U_CNT2:  next_rdata = cnt[1];
                SPR_U_SADDR: next_rdata = sampled_addr;
                SPR_U_MC1:   next_rdata = monitor_control_1;
                SPR_U_CNT3:  next_rdata = cnt[2];
                SPR_U_CNT4:  next_rdata = cnt[3];
                SPR_U_DADDR: next_rdata = 32'h0000_0000;
                SPR_MC0:     next_rdata = monitor_control_0;
                SPR_CNT1:    next_rdata = cnt[0];
                SPR_CNT2:    next_rdata = cnt[1];
                SPR_SADDR:   next_rdata = sampled_addr;
                SPR_MC1:     next_rdata = monitor_control_1;
                SPR_CNT3:    next_rdata = cnt[2];
                SPR_CNT4:    next_rdata = cnt[3];
                SPR_DADDR:   next_rdata = 32'h0000_0000;
                default:     next_fault = 1'b1;
            endcase
            // Supervisor numbers sit at 0x3b8 and above
            if (user_state_flag && spr_num[4]) begin
                next_fault = 1'b1;
                next_rdata = 32'h0000_0000;
            end
        end else if (spr_write) begin
            unique case (spr_num)
                SPR_MC0, SPR_CNT1, SPR_CNT2, SPR_SADDR,
                SPR_MC1, SPR_CNT3, SPR_CNT4: next_fault = user_state_flag;
                SPR_DADDR, SPR_U_DADDR:      next_fault = user_state_flag;
                default:                     next_fault = 1'b1;
            endcase
        end
    end

    // Read answers one cycle after the request
    always_ff @(posedge core_clk) begin
        if (rst) begin
            spr_rdata  <= 32'h0000_0000;
            spr_rvalid <= 1'b0;
            spr_fault  <= 1'b0;
        end else begin
            spr_rdata  <= next_rdata;
            spr_rvalid <= spr_read && !next_fault;
            spr_fault  <= next_fault;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    chk_freeze_all_hold: assert property (
        monitor_control_0[FREEZE_ALL_BIT] && wr_cnt == 4'h0 |=> cnt == $past(cnt))
        else $error("counter moved while frozen");
    chk_sup_block_hold: assert property (
        monitor_control_0[SUP_BLOCK_BIT] && !user_state_flag && wr_cnt == 4'h0 |=> $stable(cnt))
        else $error("counter moved in blocked supervisor state");
    chk_user_block_hold: assert property (
        monitor_control_0[USER_BLOCK_BIT] && user_state_flag && wr_cnt == 4'h0 |=> $stable(cnt))
        else $error("counter moved in blocked user state");
    chk_mark_block_hold: assert property (
        ((monitor_control_0[MARK_SET_BIT] && mark_flag)
         || (monitor_control_0[MARK_CLR_BIT] && !mark_flag)) && wr_cnt == 4'h0
        |=> $stable(cnt))
        else $error("counter moved under mark block");
    chk_arm_self_clear: assert property (
        irq_signal && !mc0_wr |=> !monitor_control_0[IRQ_ARM_BIT] && monitor_irq_pending)
        else $error("arm bit not dropped on signaling");
    chk_irq_freeze_hold: assert property (
        irq_signal && monitor_control_0[FREEZE_IRQ_BIT] && !mc0_wr
        ##1 !wr_cnt[0] && !mc0_wr |=> $stable(cnt[0]))
        else $error("counter 1 moved after freezing signal");
    chk_tb_edge_irq: assert property (
        monitor_control_0[IRQ_ARM_BIT] && monitor_control_0[TB_EDGE_BIT] && $rose(tb_bit)
        |-> irq_signal ##1 monitor_irq_pending)
        else $error("time base edge not signaled");
    chk_c1_overflow_irq: assert property (
        cnt[0][WRAP_BIT] && monitor_control_0[C1_IRQ_BIT] && monitor_control_0[IRQ_ARM_BIT]
        |=> monitor_irq_pending)
        else $error("counter 1 overflow not signaled");
    chk_no_unarmed_irq: assert property (
        !monitor_control_0[IRQ_ARM_BIT] && !monitor_irq_pending && !exception_taken
        |=> !monitor_irq_pending)
        else $error("signal without arm");
    chk_chain_hold: assert property (
        monitor_control_0[CHAIN_HOLD_BIT] && !chain_released && !wr_cnt[1] |=> $stable(cnt[1]))
        else $error("counter 2 moved before chain release");
    chk_exc_gate: assert property (
        monitor_irq_pending && !external_irq_gate |-> !monitor_exception)
        else $error("exception taken with gate clear");
    chk_user_view_read: assert property (
        spr_read && spr_num == SPR_U_CNT1 |=> spr_rvalid && spr_rdata == $past(cnt[0]))
        else $error("user view differs from counter 1");
    chk_daddr_write_ok: assert property (
        spr_write && !user_state_flag && (spr_num == SPR_DADDR || spr_num == SPR_U_DADDR)
        |=> !spr_fault)
        else $error("sampled data address write faulted");
    chk_count_step: assert property (
        count_ok[0] && hit[0] && !wr_cnt[0] |=> cnt[0] == $past(cnt[0]) + 32'h0000_0001)
        else $error("counter 1 did not step by one");

    cov_c1_overflow: cover property (
        !cnt[0][WRAP_BIT] ##1 cnt[0][WRAP_BIT] && irq_signal);
    cov_tb_irq: cover property (
        monitor_control_0[TB_EDGE_BIT] && tb_rise && irq_signal);
    cov_chain_release: cover property (
        monitor_control_0[CHAIN_HOLD_BIT] && !chain_released ##1 chain_released);
    cov_gated_exception: cover property (
        monitor_irq_pending && !external_irq_gate ##[1:20] monitor_exception);

endmodule

// ===== logic/perf_monitor_pkg.sv
// Function
// - While count_freeze_all is set, hardware never changes any event counter.
// - supervisor_count_block holds counters while the processor runs in supervisor state.
// - user_count_block holds counters while the processor runs in user state.
// - Mark-set block holds counters when mark_flag set; mark-clear block when clear.
// - monitor_irq_arm enables signaling; hardware clears it on signaling, software re-arms.
// - freeze_on_irq stops counting on signaling; when clear, counting status is unaffected.
// - timebase_bit_pick selects time base bit 63, 55, 51 or 47.
// - irq_on_timebase_edge signals an interrupt on a 0-to-1 of the picked bit.
// - A six-bit threshold field, values 0 to 63, for data-cache miss events.
// - first_counter_irq_en lets counter 1 overflow signal an interrupt.
// - other_counters_irq_en: counters 2-4 overflow signals; overrides freeze_on_irq.
// - chain_start_hold stops counters 2-4 until counter 1 top bit or signaling.
// - monitor_control_0 holds 7-bit counter 1 and 6-bit counter 2 event selectors.
// - monitor_control_1 holds two 5-bit selectors; remaining bits are reserved.
// - A counter has overflowed once its top bit is set; low 31 bits count.
// - Overflow signals only when that counter's enable and monitor_irq_arm are both set.
// - Software loading an overflow value with enables set raises the interrupt anyway.
// - The condition may arise with external_irq_gate clear; exception waits for the gate.
// - User-view registers return current contents of their supervisor counterparts.
// - Threshold-caused interrupt captures the exact overflowing instruction address.
// - Any other cause captures the address of the last completed instruction.
// - Writes to the unimplemented sampled-data-address numbers are accepted without fault; the code faults them in user state.
package perf_monitor_pkg;

    // Special register numbers
    localparam logic [9:0] SPR_U_MC0    = 10'h3a8;
    localparam logic [9:0] SPR_U_CNT1   = 10'h3a9;
    localparam logic [9:0] SPR_U_CNT2   = 10'h3aa;
    localparam logic [9:0] SPR_U_SADDR  = 10'h3ab;
    localparam logic [9:0] SPR_U_MC1    = 10'h3ac;
    localparam logic [9:0] SPR_U_CNT3   = 10'h3ad;
    localparam logic [9:0] SPR_U_CNT4   = 10'h3ae;
    localparam logic [9:0] SPR_U_DADDR  = 10'h3af;
    localparam logic [9:0] SPR_MC0      = 10'h3b8;
    localparam logic [9:0] SPR_CNT1     = 10'h3b9;
    localparam logic [9:0] SPR_CNT2     = 10'h3ba;
    localparam logic [9:0] SPR_SADDR    = 10'h3bb;
    localparam logic [9:0] SPR_MC1      = 10'h3bc;
    localparam logic [9:0] SPR_CNT3     = 10'h3bd;
    localparam logic [9:0] SPR_CNT4     = 10'h3be;
    localparam logic [9:0] SPR_DADDR    = 10'h3bf;

    // monitor_control_0 fields, bit 0 of the register is index 31
    localparam int FREEZE_ALL_BIT  = 31;
    localparam int SUP_BLOCK_BIT   = 30;
    localparam int USER_BLOCK_BIT  = 29;
    localparam int MARK_SET_BIT    = 28;
    localparam int MARK_CLR_BIT    = 27;
    localparam int IRQ_ARM_BIT     = 26;
    localparam int FREEZE_IRQ_BIT  = 25;
    localparam int TB_PICK_LSB     = 23;
    localparam int TB_EDGE_BIT     = 22;
    localparam int THRESH_LSB      = 16;
    localparam int C1_IRQ_BIT      = 15;
    localparam int OTHER_IRQ_BIT   = 14;
    localparam int CHAIN_HOLD_BIT  = 13;
    localparam int C1_SEL_LSB      = 6;
    localparam int C2_SEL_LSB      = 0;
    // monitor_control_1 fields
    localparam int C3_SEL_LSB      = 27;
    localparam int C4_SEL_LSB      = 22;
    localparam logic [31:0] MC1_MASK = 32'hffc0_0000;

    // Field widths
    localparam int TB_PICK_W  = 2;
    localparam int THRESH_W   = 6;
    localparam int C1_SEL_W   = 7;
    localparam int C2_SEL_W   = 6;
    localparam int C34_SEL_W  = 5;

    // Counter overflow bit (wrap_sign_bit)
    localparam int WRAP_BIT = 31;

    // Time base taps; bit 63 of the time base is index 0
    localparam int TB_TAP_0 = 0;
    localparam int TB_TAP_1 = 8;
    localparam int TB_TAP_2 = 12;
    localparam int TB_TAP_3 = 16;

    // Values after reset
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] CNT_RESET  = 32'h0000_0000;

endpackage

// ===== logic/sampled_addr_capture.sv
`timescale 1ns/100ps
module sampled_addr_capture
    import perf_monitor_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        rst,
    // Core instruction addresses
    input  wire logic        thresh_counted,
    input  wire logic [31:0] threshold_instr_addr,
    input  wire logic [31:0] completed_addr,
    // Capture and software write
    input  wire logic        irq_signal,
    input  wire logic        sw_write,
    input  wire logic [31:0] sw_wdata,
    output logic      [31:0] sampled_addr
);

    logic        thresh_seen;
    logic [31:0] thresh_addr;

    // Overflow shows a cycle after the counting step, so the cause is remembered
    always_ff @(posedge core_clk) begin
        if (rst) begin
            thresh_seen <= 1'b0;
            thresh_addr <= CNT_RESET;
        end else begin
            thresh_seen <= thresh_counted;
            thresh_addr <= threshold_instr_addr;
        end
    end

    // Capture on signaling wins over a software write in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sampled_addr <= CNT_RESET;
        end else if (irq_signal) begin
            sampled_addr <= thresh_seen ? thresh_addr : completed_addr;
        end else if (sw_write) begin
            sampled_addr <= sw_wdata;
        end
    end

    chk_thresh_capture: assert property (@(posedge core_clk) disable iff (rst)
        irq_signal && thresh_seen |=> sampled_addr == $past(thresh_addr))
        else $error("sampled address missed threshold instruction");
    chk_completed_capture: assert property (@(posedge core_clk) disable iff (rst)
        irq_signal && !thresh_seen |=> sampled_addr == $past(completed_addr))
        else $error("sampled address missed completed instruction");

endmodule

// ===== tb/core_model.sv
`timescale 1ns/100ps
module core_model (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    // Bench controls
    input  wire logic         tick,
    input  wire logic         tb_load,
    input  wire logic [63:0]  tb_val,
    input  wire logic [31:0]  base_addr,
    // Core side outputs
    output logic      [63:0]  timebase,
    output logic      [127:0] c1_events,
    output logic      [63:0]  c2_events,
    output logic      [31:0]  c3_events,
    output logic      [31:0]  c4_events,
    output logic      [31:0]  completed_addr
);
    // Time base moves only on load, so each tap edge is placed on purpose
    always_ff @(posedge core_clk) begin
        if (rst)
            timebase <= 64'h0;
        else if (tb_load)
            timebase <= tb_val;
    end
    // One tick drives every line, so any selector value sees it
    assign c1_events      = {128{tick}};
    assign c2_events      = {64{tick}};
    assign c3_events      = {32{tick}};
    assign c4_events      = {32{tick}};
    assign completed_addr = base_addr;
endmodule

// ===== tb/testbench.sv
`timescale 1ns/100ps
module testbench
    import perf_monitor_pkg::*;
;
    localparam logic [31:0] ARM = 32'h1 << IRQ_ARM_BIT;
    localparam logic [31:0] C1E = 32'h1 << C1_IRQ_BIT;
    localparam logic [31:0] OTH = 32'h1 << OTHER_IRQ_BIT;
    localparam logic [31:0] FRZ = 32'h1 << FREEZE_IRQ_BIT;
    localparam logic [31:0] OVF = 32'h8000_0000;
    // Wiring and bench state
    logic         core_clk, rst, spr_write, spr_read, spr_rvalid, spr_fault, thr, tick;
    logic [1:0]   flt;
    logic         user_state_flag, mark_flag, external_irq_gate, exception_taken, tb_load;
    logic         monitor_irq_pending, monitor_exception;
    logic [9:0]   spr_num;
    logic [31:0]  spr_wdata, spr_rdata, base_addr, completed_addr, c3_events, c4_events, d, v;
    logic [63:0]  timebase, tb_val, c2_events;
    logic [127:0] c1_events;
    logic [5:0]   threshold_value;
    logic [31:0]  seed = 32'h1a74;
    int           error_cnt = 0, comparisons = 0, n, t, o;
    // Scenario tables
    logic [9:0]   regs[6] = '{SPR_MC0, SPR_MC1, SPR_CNT1, SPR_CNT2, SPR_CNT3, SPR_CNT4};
    logic [9:0]   uv[6] = '{SPR_U_MC0, SPR_U_MC1, SPR_U_CNT1, SPR_U_CNT2, SPR_U_CNT3, SPR_U_CNT4};
    int           bp[9] = '{C2_SEL_LSB, FREEZE_ALL_BIT, SUP_BLOCK_BIT, SUP_BLOCK_BIT,
        USER_BLOCK_BIT, MARK_SET_BIT, MARK_CLR_BIT, MARK_CLR_BIT, CHAIN_HOLD_BIT};
    logic [3:0]   ce[9] = '{4'hf, 4'h0, 4'h0, 4'hf, 4'h0, 4'h0, 4'h0, 4'hf, 4'h1};
    logic [31:0]  im[7] = '{ARM, ARM | C1E, ARM | C1E, ARM | OTH, C1E, ARM | C1E | FRZ,
        ARM | OTH | FRZ};
    int           it[7] = '{2, 3, 2, 4, 2, 2, 4};
    int           tp[4] = '{TB_TAP_0, TB_TAP_1, TB_TAP_2, TB_TAP_3};

    perf_monitor_counters dut (
        .core_clk, .rst, .spr_num, .spr_write, .spr_read, .spr_wdata, .spr_rdata,
        .spr_rvalid, .spr_fault, .user_state_flag, .mark_flag, .external_irq_gate,
        .exception_taken, .timebase, .c1_events, .c2_events, .c3_events, .c4_events,
        .threshold_event(thr), .threshold_instr_addr(~base_addr), .completed_addr,
        .threshold_value, .monitor_irq_pending, .monitor_exception);
    core_model partner (
        .core_clk, .rst, .tick, .tb_load, .tb_val, .base_addr, .timebase,
        .c1_events, .c2_events, .c3_events, .c4_events, .completed_addr);

    // Free running clock
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    // Hang guard, far above the longest legal run
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        results();
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic results();
        $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Register accesses: one cycle request, answer seen at the next falling edge
    task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] x);
        @(negedge core_clk);
        spr_write = w;
        spr_read = ~w;
        spr_num = a;
        spr_wdata = x;
        @(negedge core_clk);
        {spr_write, spr_read} = 2'b00;
        d = spr_rdata;
        flt = {spr_rvalid, spr_fault};
    endtask
    task automatic ld(input logic [63:0] x);
        @(negedge core_clk);
        tb_load = 1'b1;
        tb_val = x;
        @(negedge core_clk);
        tb_load = 1'b0;
    endtask
    task automatic clr();
        @(negedge core_clk);
        exception_taken = 1'b1;
        @(negedge core_clk);
        exception_taken = 1'b0;
    endtask

    initial begin
        {rst, spr_write, spr_read, user_state_flag, mark_flag} = 5'b10000;
        {external_irq_gate, exception_taken, tick, tb_load, thr} = 5'h0;
        {spr_num, spr_wdata, tb_val, base_addr} = 138'h0;
        repeat (10) @(negedge core_clk);
        rst = 1'b0;
        // Reset contents, write then read through both views
        for (int i = 0; i < 6; i++) begin
            acc(1'b0, regs[i], 32'h0);
            chk(d, 32'h0);
            v = rnd() & 32'h7fff_ffff;
            acc(1'b1, regs[i], v);
            v &= (i == 1) ? MC1_MASK : 32'hffff_ffff;
            acc(1'b0, regs[i], 32'h0);
            chk(d, v);
            if (i == 0) chk(32'(threshold_value), 32'(v[THRESH_LSB +: THRESH_W]));
            user_state_flag = 1'b1;
            acc(1'b0, uv[i], 32'h0);
            chk(d, v);
            chk(32'(flt), 32'h2);
            user_state_flag = 1'b0;
        end
        acc(1'b0, 10'h3c0, 32'h0);
        chk(32'(flt), 32'h1);
        acc(1'b1, SPR_DADDR, rnd());
        chk(32'(flt), 32'h0);
        acc(1'b1, SPR_U_DADDR, rnd());
        chk(32'(flt), 32'h0);
        // Count gating table against a tick count kept in the bench
        for (int k = 0; k < 9; k++) begin
            acc(1'b1, SPR_MC0, 32'h0);
            for (int c = 2; c < 6; c++) acc(1'b1, regs[c], 32'h0);
            acc(1'b1, SPR_MC0, 32'h1 << bp[k]);
            user_state_flag = k inside {3, 4};
            mark_flag = k inside {5, 7};
            n = 0;
            repeat (20) begin
                @(negedge core_clk);
                v = rnd();
                tick = v[0];
                n += v[0];
            end
            @(negedge core_clk);
            {tick, user_state_flag} = 2'b00;
            for (int c = 0; c < 4; c++) begin
                acc(1'b0, regs[c + 2], 32'h0);
                chk(d, ce[k][c] ? n : 0);
            end
        end
        // Overflow interrupt table; the gate stays shut until the condition is seen
        for (int k = 0; k < 7; k++) begin
            external_irq_gate = 1'b0;
            acc(1'b1, SPR_MC0, 32'h0);
            for (int c = 2; c < 6; c++) acc(1'b1, regs[c], 32'h0);
            clr();
            base_addr = rnd();
            acc(1'b1, SPR_MC0, im[k]);
            acc(1'b1, regs[it[k]], (k == 2) ? OVF - 32'h1 : OVF);
            // Case 2 overflows through one counted threshold event, not a load
            {tick, thr} = (k == 2) ? 2'b11 : 2'b00;
            @(negedge core_clk);
            {tick, thr} = 2'b00;
            if (k == 2) @(negedge core_clk);
            chk(32'(monitor_irq_pending), 32'(k inside {2, 3, 5, 6}));
            chk(32'(monitor_exception), 32'h0);
            if (k inside {2, 3, 5, 6}) begin
                external_irq_gate = 1'b1;
                #1 chk(32'(monitor_exception), 32'h1);
                acc(1'b0, SPR_MC0, 32'h0);
                chk(d, im[k] & ~ARM);
                acc(1'b0, SPR_SADDR, 32'h0);
                chk(d, (k == 2) ? ~base_addr : base_addr);
                @(negedge core_clk);
                tick = 1'b1;
                repeat (5) @(negedge core_clk);
                tick = 1'b0;
                acc(1'b0, regs[it[k]], 32'h0);
                chk(d, OVF + ((k == 5) ? 32'h0 : 32'h5));
            end
        end
        // Time base taps: a rise on another tap stays silent, the picked one signals
        for (int p = 0; p < 4; p++) begin
            t = tp[p];
            o = tp[(p + 1) % 4];
            v = (32'h1 << TB_EDGE_BIT) | (32'(p) << TB_PICK_LSB);
            acc(1'b1, SPR_MC0, v);
            ld((64'h1 << o) - 64'h1);
            clr();
            acc(1'b1, SPR_MC0, v | ARM);
            ld(64'h1 << o);
            @(negedge core_clk);
            chk(32'(monitor_irq_pending), 32'h0);
            ld((64'h1 << t) - 64'h1);
            ld(64'h1 << t);
            @(negedge core_clk);
            chk(32'(monitor_irq_pending), 32'h1);
        end
        results();
    end
endmodule
